// File: pcm_highway_consts.vh
`ifndef PCM_HIGHWAY_CONSTS_VH
`define PCM_HIGHWAY_CONSTS_VH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define ADDR_MODE_SELECT   7'h21
`define ADDR_TX_START_LOW  7'h22
`define ADDR_TX_START_HIGH 7'h23
`define ADDR_RX_START_LOW  7'h24
`define ADDR_RX_START_HIGH 7'h25
`define ADDR_TX_GAIN       7'h26
`define RESET_BYTE         8'h00
// ----------------------------------------
// mode select fields
// ----------------------------------------
`define BIT_LOOPBACK       7
`define BIT_RELEASE_MODE   6
`define BIT_XFER_ENABLE    5
`define FMT_MSB            4
`define FMT_LSB            3
`define BIT_CLOCK_RATIO    1
`define BIT_RELEASE_EDGE   0
`define FMT_ALAW           2'h0
`define FMT_MULAW          2'h1
`define FMT_LIN8           2'h2
`define FMT_LIN16          2'h3
// ----------------------------------------
// gain fields
// ----------------------------------------
`define BIT_TX_DIRECTION   4
`define TX_GAIN_MAX_DB     4'hC
// ----------------------------------------
// serial control frame
// ----------------------------------------
`define SPI_HDR_BITS       5'h07
`define SPI_LAST_BIT       5'h0F
`define SPI_DONE           5'h10
// ----------------------------------------
// input synchroniser lanes
// ----------------------------------------
`define IN_SCLK            0
`define IN_CS_N            1
`define IN_SDI             2
`define IN_PCLK            3
`define IN_FRAME           4
`define IN_DRX             5
`define ALAW_XOR           8'h55
`define MULAW_CLIP         16'h1FDE
`define MULAW_BIAS         16'h0021
`define POS_MAX            11'h7FF
`endif

// File: two_entry_buffer.v
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
  parameter WIDTH = 16
) (
  input  wire             mclk_in,
  input  wire             nrst_in,
  input  wire [WIDTH-1:0] in_data_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  output wire [WIDTH-1:0] out_data_out,
  output wire             out_valid_out,
  input  wire             out_ready_in
);
  reg [WIDTH-1:0] head_ff;
  reg [WIDTH-1:0] spare_ff;
  reg             head_v_ff;
  reg             spare_v_ff;
  reg             ready_ff;
  wire            push;
  wire            pop;
  // ready mirrors a free spare entry, kept as its own flop for the port
  assign push          = in_valid_in & ready_ff;
  assign pop           = head_v_ff & out_ready_in;
  assign in_ready_out  = ready_ff;
  assign out_data_out  = head_ff;
  assign out_valid_out = head_v_ff;
  // ----------------------------------------
  // head is the output word, spare absorbs one stall
  // ----------------------------------------
  always @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      head_ff    <= {WIDTH{1'b0}};
      spare_ff   <= {WIDTH{1'b0}};
      head_v_ff  <= 1'b0;
      spare_v_ff <= 1'b0;
      ready_ff   <= 1'b1;
    end
    else if (!head_v_ff)
    begin
      if (push)
      begin
        head_ff   <= in_data_in;
        head_v_ff <= 1'b1;
      end
    end
    else if (!pop)
    begin
      if (push)
      begin
        spare_ff   <= in_data_in;
        spare_v_ff <= 1'b1;
        ready_ff   <= 1'b0;
      end
    end
    else if (spare_v_ff)
    begin
      head_ff    <= spare_ff;
      spare_v_ff <= 1'b0;
      ready_ff   <= 1'b1;
    end
    else if (push)
      head_ff <= in_data_in;
    else
      head_v_ff <= 1'b0;
  end
endmodule // two_entry_buffer
`default_nettype wire

// File: pcm_highway_port.v
// Contract
// - loopback bit high routes line samples rx filter back to tx filter
// - release mode 0 frees sdo at cs rise, 1 at last sclk rise
// - highway transfers happen only while the transfer enable bit is one
// - format 00 carries a-law, 01 mu-law, both signed magnitude
// - format 10 sends upper eight bits of sixteen bit sample
// - format 11 sends full sixteen bit two's complement samples
// - ratio bit picks one or two bit clocks per data bit
// - release edge bit frees last transmit bit on rising or falling edge
// - transmit starts after ten bit count of bit clocks past frame strobe
// - receive starts after its own ten bit count past frame strobe
// - direction bit picks whether higher step codes gain or attenuate
// - each step is one decibel, gain up to 12, attenuation to 15
// - step code zero applies no gain and no attenuation
// - gain direction codes with top two bits set saturate at 12 db
`timescale 1ns/1ps
`default_nettype none
`include "pcm_highway_consts.vh"
module pcm_highway_port (
  input  wire        mclk_in,
  input  wire        nrst_in,
  input  wire        sclk_in,
  input  wire        cs_n_in,
  input  wire        sdi_in,
  output wire        sdo_out,
  output wire        sdo_oe_out,
  input  wire        pclk_in,
  input  wire        frame_strobe_in,
  input  wire        pcm_rx_in,
  output wire        pcm_tx_out,
  output wire        pcm_tx_oe_out,
  input  wire [15:0] tx_sample_in,
  input  wire        tx_valid_in,
  output wire        tx_ready_out,
  output wire [15:0] rx_sample_out,
  output wire        rx_valid_out,
  input  wire        rx_ready_in,
  output wire        analog_loopback_enable_out,
  output wire [3:0]  tx_gain_db_out,
  output wire        tx_attenuate_out
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  reg  [5:0] s1_ff;
  reg  [5:0] s2_ff;
  reg  [5:0] s3_ff;
  reg  [5:0] st_ff;
  wire [5:0] agree  = ~(s2_ff ^ s3_ff);
  wire [5:0] nxt_st = (agree & s3_ff) | (~agree & st_ff);
  wire [5:0] rise   = nxt_st & ~st_ff;
  wire [5:0] fall   = ~nxt_st & st_ff;
  always @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      // idle pin levels, so no false select edge follows reset
      s1_ff <= 6'h02;
      s2_ff <= 6'h02;
      s3_ff <= 6'h02;
      st_ff <= 6'h02;
    end
    else
    begin
      s1_ff <= {pcm_rx_in, frame_strobe_in, pclk_in, sdi_in, cs_n_in, sclk_in};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      st_ff <= nxt_st;
    end
  end
  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  reg  [7:0] mode_ff;
  reg  [7:0] txs_lo_ff;
  reg  [1:0] txs_hi_ff;
  reg  [7:0] rxs_lo_ff;
  reg  [1:0] rxs_hi_ff;
  reg  [4:0] gain_ff;
  wire [1:0] fmt      = mode_ff[`FMT_MSB:`FMT_LSB];
  wire       ratio    = mode_ff[`BIT_CLOCK_RATIO];
  wire       enable   = mode_ff[`BIT_XFER_ENABLE];
  wire [9:0] tx_start = {txs_hi_ff, txs_lo_ff};
  wire [9:0] rx_start = {rxs_hi_ff, rxs_lo_ff};
  // ----------------------------------------
  // serial control port
  // ----------------------------------------
  reg  [15:0] shift_ff;
  reg  [4:0]  bitcnt_ff;
  reg         rd_req_ff;
  reg  [6:0]  addr_ff;
  reg  [7:0]  rd_shift_ff;
  reg         sdo_ff;
  reg         sdo_oe_ff;
  wire        cs_low   = ~st_ff[`IN_CS_N];
  wire        sdi      = st_ff[`IN_SDI];
  wire        sck_up   = cs_low & rise[`IN_SCLK];
  wire        sck_dn   = cs_low & fall[`IN_SCLK];
  wire [6:0]  hdr_addr = {shift_ff[5:0], sdi};
  wire        wr_stb   = sck_up & (bitcnt_ff == `SPI_LAST_BIT) & ~rd_req_ff;
  wire [7:0]  wr_data  = {shift_ff[6:0], sdi};
  wire [7:0]  rd_val   = (hdr_addr == `ADDR_MODE_SELECT)   ? mode_ff :
                         (hdr_addr == `ADDR_TX_START_LOW)  ? txs_lo_ff :
                         (hdr_addr == `ADDR_TX_START_HIGH) ? {6'h00, txs_hi_ff} :
                         (hdr_addr == `ADDR_RX_START_LOW)  ? rxs_lo_ff :
                         (hdr_addr == `ADDR_RX_START_HIGH) ? {6'h00, rxs_hi_ff} :
                         (hdr_addr == `ADDR_TX_GAIN)       ? {3'h0, gain_ff} : 8'h00;
  always @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      shift_ff    <= 16'h0000;
      bitcnt_ff   <= 5'h00;
      rd_req_ff   <= 1'b0;
      addr_ff     <= 7'h00;
      rd_shift_ff <= 8'h00;
      sdo_ff      <= 1'b0;
      sdo_oe_ff   <= 1'b0;
    end
    else if (rise[`IN_CS_N])
    begin
      bitcnt_ff <= 5'h00;
      sdo_oe_ff <= 1'b0;
    end
    else if (fall[`IN_CS_N])
      bitcnt_ff <= 5'h00;
    else if (sck_up && bitcnt_ff != `SPI_DONE)
    begin
      shift_ff  <= {shift_ff[14:0], sdi};
      bitcnt_ff <= bitcnt_ff + 5'h01;
      if (bitcnt_ff == `SPI_HDR_BITS)
      begin
        rd_req_ff   <= shift_ff[6];
        addr_ff     <= hdr_addr;
        rd_shift_ff <= rd_val;
      end
      if (bitcnt_ff == `SPI_LAST_BIT && mode_ff[`BIT_RELEASE_MODE])
        sdo_oe_ff <= 1'b0;
    end
    else if (sck_dn && rd_req_ff && bitcnt_ff > `SPI_HDR_BITS && bitcnt_ff < `SPI_DONE)
    begin
      sdo_ff      <= rd_shift_ff[7];
      rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
      sdo_oe_ff   <= 1'b1;
    end
  end
  // reserved bit two is stored as written; software keeps it zero
  always @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      mode_ff   <= `RESET_BYTE;
      txs_lo_ff <= `RESET_BYTE;
      txs_hi_ff <= 2'h0;
      rxs_lo_ff <= `RESET_BYTE;
      rxs_hi_ff <= 2'h0;
      gain_ff   <= 5'h00;
    end
    else if (wr_stb)
    begin
      case (addr_ff)
        `ADDR_MODE_SELECT:   mode_ff   <= wr_data;
        `ADDR_TX_START_LOW:  txs_lo_ff <= wr_data;
        `ADDR_TX_START_HIGH: txs_hi_ff <= wr_data[1:0];
        `ADDR_RX_START_LOW:  rxs_lo_ff <= wr_data;
        `ADDR_RX_START_HIGH: rxs_hi_ff <= wr_data[1:0];
        `ADDR_TX_GAIN:       gain_ff   <= wr_data[4:0];
        default:             gain_ff   <= gain_ff;
      endcase
    end
  end
  // ----------------------------------------
  // companding encoder
  // ----------------------------------------
  function [7:0] compand;
    input [15:0] x;
    input        mu;
    reg   [15:0] mag;
    reg   [15:0] sh;
    reg   [2:0]  ex;
    integer      i;
    begin
      mag = x[15] ? (~x + 16'h0001) : x;
      mag = mu ? (mag >> 2) : (mag >> 3);
      if (mu)
        mag = ((mag > `MULAW_CLIP) ? `MULAW_CLIP : mag) + `MULAW_BIAS;
      ex = 3'h0;
      for (i = 5; i < 13; i = i + 1)
        if (mag[i] && (mu || i < 12))
          ex = i[2:0] - (mu ? 3'h5 : 3'h4);
      // four-bit shift count: top segment needs a shift of eight
      sh = (mu || ex != 3'h0) ? (mag >> ({1'b0, ex} + {3'h0, mu})) : (mag >> 1);
      compand = mu ? ~{x[15], ex, sh[3:0]} : ({~x[15], ex, sh[3:0]} ^ `ALAW_XOR);
    end
  endfunction
  // ----------------------------------------
  // highway framing
  // ----------------------------------------
  reg  [10:0] pos_ff;
  reg         frame_ok_ff;
  reg         fs_prev_ff;
  reg         upd_ff;
  reg  [15:0] tx_word_ff;
  reg         tx_ff;
  reg         tx_oe_ff;
  reg  [15:0] rx_word_ff;
  reg         rx_push_ff;
  wire        pclk_up  = rise[`IN_PCLK];
  wire        fs_new   = pclk_up & st_ff[`IN_FRAME] & ~fs_prev_ff;
  wire        wide     = (fmt == `FMT_LIN16);
  wire [5:0]  span     = (wide ? 6'h10 : 6'h08) << ratio;
  wire [10:0] tx_rel   = pos_ff - {1'b0, tx_start};
  wire [10:0] rx_rel   = pos_ff - {1'b0, rx_start};
  wire        tx_win   = frame_ok_ff & enable & (pos_ff >= {1'b0, tx_start}) &
                         (tx_rel < {5'h00, span});
  wire        rx_win   = frame_ok_ff & enable & (pos_ff >= {1'b0, rx_start}) &
                         (rx_rel < {5'h00, span});
  wire [10:0] tx_bit   = ratio ? (tx_rel >> 1) : tx_rel;
  wire [10:0] rx_bit   = ratio ? (rx_rel >> 1) : rx_rel;
  wire [3:0]  tx_idx   = (wide ? 4'hF : 4'h7) - tx_bit[3:0];
  wire        rx_last  = (rx_bit[4:0] == (wide ? 5'h0F : 5'h07));
  wire [15:0] buf_data;
  wire        buf_valid;
  wire        tx_pop   = fs_new & enable & buf_valid;
  wire [15:0] src      = buf_valid ? buf_data : 16'h0000;
  wire [7:0]  code     = compand(src, fmt[0]);
  wire [15:0] fmt_word = (fmt == `FMT_LIN16) ? src :
                         (fmt == `FMT_LIN8) ? {8'h00, src[15:8]} : {8'h00, code};
  always @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pos_ff      <= 11'h000;
      frame_ok_ff <= 1'b0;
      fs_prev_ff  <= 1'b0;
      upd_ff      <= 1'b0;
      tx_word_ff  <= 16'h0000;
      tx_ff       <= 1'b0;
      tx_oe_ff    <= 1'b0;
      rx_word_ff  <= 16'h0000;
      rx_push_ff  <= 1'b0;
    end
    else
    begin
      upd_ff     <= pclk_up;
      rx_push_ff <= 1'b0;
      if (pclk_up)
      begin
        fs_prev_ff <= st_ff[`IN_FRAME];
        if (fs_new)
        begin
          pos_ff      <= 11'h000;
          frame_ok_ff <= 1'b1;
          tx_word_ff  <= fmt_word;
        end
        else if (pos_ff != `POS_MAX)
          pos_ff <= pos_ff + 11'h001;
      end
      // bits change one mclk after the rising bit clock edge
      if (upd_ff)
      begin
        if (tx_win)
        begin
          tx_ff    <= tx_word_ff[tx_idx];
          tx_oe_ff <= 1'b1;
        end
        else
          tx_oe_ff <= 1'b0;
      end
      else if (fall[`IN_PCLK])
      begin
        if (mode_ff[`BIT_RELEASE_EDGE] && tx_win && tx_rel == {5'h00, span} - 11'h001)
          tx_oe_ff <= 1'b0;
        // two-clock bits are sampled in their first period
        if (rx_win && !(ratio && rx_rel[0]))
        begin
          rx_word_ff <= {rx_word_ff[14:0], st_ff[`IN_DRX]};
          rx_push_ff <= rx_last;
        end
      end
    end
  end
  // ----------------------------------------
  // sample buffers
  // ----------------------------------------
  wire [15:0] rx_fmt   = (fmt == `FMT_LIN8) ? {rx_word_ff[7:0], 8'h00} :
                         (fmt == `FMT_LIN16) ? rx_word_ff : {8'h00, rx_word_ff[7:0]};
  two_entry_buffer #(.WIDTH(16)) tx_buf (
    .mclk_in       (mclk_in),
    .nrst_in       (nrst_in),
    .in_data_in    (tx_sample_in),
    .in_valid_in   (tx_valid_in),
    .in_ready_out  (tx_ready_out),
    .out_data_out  (buf_data),
    .out_valid_out (buf_valid),
    .out_ready_in  (tx_pop)
  );
  // a word arriving while both entries are held is dropped; the link cannot stall
  two_entry_buffer #(.WIDTH(16)) rx_buf (
    .mclk_in       (mclk_in),
    .nrst_in       (nrst_in),
    .in_data_in    (rx_fmt),
    .in_valid_in   (rx_push_ff),
    .in_ready_out  (),
    .out_data_out  (rx_sample_out),
    .out_valid_out (rx_valid_out),
    .out_ready_in  (rx_ready_in)
  );
  // ----------------------------------------
  // coarse transmit gain
  // ----------------------------------------
  reg  [4:0] gain_out_ff;
  wire [3:0] step      = gain_ff[3:0];
  wire       nxt_atten = gain_ff[`BIT_TX_DIRECTION] & (step != 4'h0);
  wire [3:0] nxt_db    = (!nxt_atten && step[3:2] == 2'h3) ? `TX_GAIN_MAX_DB : step;
  always @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      gain_out_ff <= 5'h00;
    else
      gain_out_ff <= {nxt_atten, nxt_db};
  end
  assign sdo_out                    = sdo_ff;
  assign sdo_oe_out                 = sdo_oe_ff;
  assign pcm_tx_out                 = tx_ff;
  assign pcm_tx_oe_out              = tx_oe_ff;
  assign analog_loopback_enable_out = mode_ff[`BIT_LOOPBACK];
  assign tx_gain_db_out             = gain_out_ff[3:0];
  assign tx_attenuate_out           = gain_out_ff[4];
endmodule // pcm_highway_port
`default_nettype wire

// File: pcm_highway_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module pcm_highway_port_props (
  input wire logic        mclk_in,
  input wire logic        nrst_in,
  input wire logic        cs_n_in,
  input wire logic        sdo_oe_out,
  input wire logic        pclk_in,
  input wire logic        pcm_tx_oe_out,
  input wire logic [15:0] rx_sample_out,
  input wire logic        rx_valid_out,
  input wire logic        rx_ready_in,
  input wire logic [3:0]  tx_gain_db_out,
  input wire logic        tx_attenuate_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  // ----
  // pclk age counters
  // ----
  logic [5:0] hi_ago_ff;
  logic [5:0] still_ff;
  logic       pclk_d_ff;
  always_ff @(posedge mclk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      hi_ago_ff <= 6'h3F;
      still_ff  <= 6'h3F;
      pclk_d_ff <= 1'b0;
    end
    else
    begin
      hi_ago_ff <= pclk_in ? 6'h00 : hi_ago_ff + {5'h00, ~&hi_ago_ff};
      still_ff  <= (pclk_in ^ pclk_d_ff) ? 6'h00 : still_ff + {5'h00, ~&still_ff};
      pclk_d_ff <= pclk_in;
    end
  // ----
  // properties
  // ----
  a_sdo_idle_off: assert property (cs_n_in [*8] |-> !sdo_oe_out)
    else $error("sdo driven while deselected");
  a_sdo_rise_sel: assert property ($rose(sdo_oe_out) |-> !cs_n_in)
    else $error("sdo enabled without select");
  a_gain_cap: assert property (!tx_attenuate_out |-> tx_gain_db_out <= 4'hC)
    else $error("gain above cap");
  a_zero_code: assert property (tx_attenuate_out |-> tx_gain_db_out != 4'h0)
    else $error("attenuation with zero step");
  a_rx_word_hold: assert property (rx_valid_out && !rx_ready_in
    |=> rx_valid_out && $stable(rx_sample_out)) else $error("rx word lost");
  a_rx_pop_only: assert property ($fell(rx_valid_out) |-> $past(rx_ready_in))
    else $error("rx word dropped unread");
  a_tx_at_pclk: assert property ($rose(pcm_tx_oe_out) |-> hi_ago_ff < 6'd8)
    else $error("tx drive off pclk edge");
  a_tx_in_frame: assert property (pcm_tx_oe_out |-> still_ff < 6'd20)
    else $error("tx driven with pclk stopped");
  c_read: cover property ($rose(sdo_oe_out));
  c_tx: cover property ($rose(pcm_tx_oe_out));
  c_att: cover property ($rose(tx_attenuate_out));
endmodule // pcm_highway_port_props
bind pcm_highway_port pcm_highway_port_props i_props (.mclk_in, .nrst_in, .cs_n_in,
  .sdo_oe_out, .pclk_in, .pcm_tx_oe_out, .rx_sample_out, .rx_valid_out, .rx_ready_in,
  .tx_gain_db_out, .tx_attenuate_out);
`default_nettype wire

// File: pcm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcm_host_model (
  output logic      pclk_out,
  output logic      frame_strobe_out,
  output logic      pcm_rx_out,
  input  wire logic pcm_tx_in,
  input  wire logic pcm_tx_oe_in
);
  logic [31:0] cap_bits;
  int          cap_count;
  int          first_pos;
  initial
  begin
    pclk_out = 1'b0;
    frame_strobe_out = 1'b0;
    pcm_rx_out = 1'b0;
  end
  // ----
  // one frame; clock stands still after it
  // ----
  task automatic frame(input int rx_pos, input int len, input int ratio,
                       input logic [15:0] word);
    int p;
    int b;
    cap_bits = 32'h0;
    cap_count = 0;
    first_pos = -1;
    frame_strobe_out = 1'b1;
    // strobe set up half a period before the rise that samples it
    #100;
    for (p = 0; p < 40; p++)
    begin
      b = (p - rx_pos) >> ratio;
      // toggle outside the slot so stale data never looks valid
      pcm_rx_out = (p >= rx_pos && b < len) ? word[len - 1 - b] : ~pcm_rx_out;
      pclk_out = 1'b1;
      #100;
      pclk_out = 1'b0;
      frame_strobe_out = 1'b0;
      #100;
      if (pcm_tx_oe_in === 1'b1)
      begin
        if (first_pos < 0) first_pos = p;
        cap_bits = {cap_bits[30:0], pcm_tx_in};
        cap_count++;
      end
    end
  endtask
endmodule // pcm_host_model
`default_nettype wire

// File: pcm_highway_port_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcm_highway_consts.vh"
module pcm_highway_port_config_tb;
  logic        mclk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        sclk_in = 1'b0;
  logic        cs_n_in = 1'b1;
  logic        sdi_in = 1'b0;
  logic        rx_ready_in = 1'b0;
  logic        tx_valid_in = 1'b0;
  logic [15:0] tx_sample_in = 16'h0000;
  wire         sdo_out, sdo_oe_out, pclk_in, frame_strobe_in, pcm_rx_in;
  wire         pcm_tx_out, pcm_tx_oe_out, tx_ready_out, rx_valid_out;
  wire         analog_loopback_enable_out, tx_attenuate_out;
  wire [15:0]  rx_sample_out;
  wire [3:0]   tx_gain_db_out;
  int          fail_count = 0;
  int          checks_done = 0;
  int          i;
  logic [3:0]  db;
  localparam logic [22:0] reg_tab [6] = '{{7'h22, 16'hA5A5}, {7'h23, 16'hFF03},
    {7'h24, 16'h5A5A}, {7'h25, 16'hFE02}, {7'h26, 16'hFF1F}, {7'h30, 16'hFF00}};
  localparam logic [15:0] tx_exp [4] = '{16'h00D5, 16'h00FF, 16'h0081, 16'h8123};
  localparam logic [15:0] rx_snd [4] = '{16'h003C, 16'h003C, 16'h00C3, 16'hC3A5};
  localparam logic [15:0] rx_exp [4] = '{16'h003C, 16'h003C, 16'hC300, 16'hC3A5};
  always #12.5 mclk_in = ~mclk_in;
  pcm_highway_port i_dut (.mclk_in, .nrst_in, .sclk_in, .cs_n_in, .sdi_in, .sdo_out,
    .sdo_oe_out, .pclk_in, .frame_strobe_in, .pcm_rx_in, .pcm_tx_out, .pcm_tx_oe_out,
    .tx_sample_in, .tx_valid_in, .tx_ready_out, .rx_sample_out, .rx_valid_out,
    .rx_ready_in, .analog_loopback_enable_out, .tx_gain_db_out, .tx_attenuate_out);
  pcm_host_model i_host (.pclk_out(pclk_in), .frame_strobe_out(frame_strobe_in),
    .pcm_rx_out(pcm_rx_in), .pcm_tx_in(pcm_tx_out), .pcm_tx_oe_in(pcm_tx_oe_out));
  // ----
  // helpers
  // ----
  task end_sim;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #2;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task hold_until(input logic want_rx);
    int k;
    for (k = 0; (want_rx ? rx_valid_out : tx_ready_out) !== 1'b1; k++)
    begin
      if (k == 60)
      begin
        chk(1'b0, 1'b1);
        end_sim;
      end
      cyc(1);
    end
  endtask
  // sclk halves of 8 mclk keep the 3-flop sync happy
  task spi(input logic rd, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q,
           output logic oe);
    logic [15:0] w;
    int b;
    w = {rd, a, d};
    cs_n_in = 1'b0;
    cyc(8);
    for (b = 15; b >= 0; b--)
    begin
      sdi_in = w[b];
      cyc(8);
      if (b < 8) q = {q[6:0], sdo_out};
      sclk_in = 1'b1;
      cyc(8);
      sclk_in = 1'b0;
    end
    cyc(8);
    oe = sdo_oe_out;
    cs_n_in = 1'b1;
    cyc(12);
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic o;
    spi(1'b0, a, d, q, o);
  endtask
  task rd(input logic [6:0] a, input logic [7:0] e, input logic oe_e);
    logic [7:0] q;
    logic o;
    spi(1'b1, a, 8'h00, q, o);
    chk(q, e);
    chk(o, oe_e);
  endtask
  task push(input logic [15:0] s);
    cyc(1);
    tx_sample_in = s;
    tx_valid_in = 1'b1;
    hold_until(1'b0);
    cyc(1);
    tx_valid_in = 1'b0;
  endtask
  task pop(input logic [15:0] e);
    hold_until(1'b1);
    chk(rx_sample_out, e);
    rx_ready_in = 1'b1;
    cyc(1);
    rx_ready_in = 1'b0;
    cyc(1);
  endtask
  task fr(input int len, input int r, input logic [15:0] w);
    i_host.frame(3, len, r, w);
    cyc(1);
  endtask
  // ----
  // sequence
  // ----
  initial
  begin
    repeat (4) @(posedge mclk_in);
    #2;
    nrst_in = 1'b1;
    cyc(4);
    for (i = 0; i < 7; i++)
      rd(i == 6 ? 7'h30 : 7'h21 + i[6:0], `RESET_BYTE, 1'b1);
    for (i = 0; i < 6; i++)
    begin
      wr(reg_tab[i][22:16], reg_tab[i][15:8]);
      rd(reg_tab[i][22:16], reg_tab[i][7:0], 1'b1);
    end
    wr(`ADDR_MODE_SELECT, 8'hDB);
    rd(`ADDR_MODE_SELECT, 8'hDB, 1'b0);
    chk(analog_loopback_enable_out, 1'b1);
    wr(`ADDR_MODE_SELECT, 8'h00);
    chk(analog_loopback_enable_out, 1'b0);
    for (i = 0; i < 32; i++)
    begin
      wr(`ADDR_TX_GAIN, i[7:0]);
      db = (!i[4] && i[3:2] == 2'b11) ? `TX_GAIN_MAX_DB : i[3:0];
      chk(tx_gain_db_out, db);
      chk(tx_attenuate_out, i[4] && i[3:0] != 4'h0);
    end
    wr(`ADDR_TX_START_LOW, 8'h02);
    wr(`ADDR_TX_START_HIGH, 8'h00);
    wr(`ADDR_RX_START_LOW, 8'h03);
    wr(`ADDR_RX_START_HIGH, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      if (i > 1) push(16'h8123);
      wr(`ADDR_MODE_SELECT, {3'b001, i[1:0], 3'b000});
      fr(i == 3 ? 16 : 8, 0, rx_snd[i]);
      chk(i_host.cap_count, i == 3 ? 16 : 8);
      chk(i_host.cap_bits, {16'h0000, tx_exp[i]});
      chk(i_host.first_pos, 2);
      pop(rx_exp[i]);
    end
    wr(`ADDR_TX_START_LOW, 8'h05);
    push(16'h8123);
    wr(`ADDR_MODE_SELECT, 8'h32);
    fr(8, 1, 16'h00C3);
    chk(i_host.cap_count, 16);
    chk(i_host.cap_bits, 32'h0000C003);
    chk(i_host.first_pos, 5);
    pop(16'hC300);
    // buffer full, receiver stalled across two frames
    wr(`ADDR_MODE_SELECT, 8'h38);
    push(16'h1111);
    push(16'h2222);
    cyc(2);
    chk(tx_ready_out, 1'b0);
    fr(16, 0, 16'hAAAA);
    chk(i_host.cap_bits, 32'h00001111);
    fr(16, 0, 16'h5555);
    chk(i_host.cap_bits, 32'h00002222);
    pop(16'hAAAA);
    pop(16'h5555);
    wr(`ADDR_MODE_SELECT, 8'h18);
    push(16'h3333);
    fr(16, 0, 16'h1234);
    chk(i_host.cap_count, 0);
    chk(rx_valid_out, 1'b0);
    // falling-edge release drops the last bit before the host takes it
    wr(`ADDR_MODE_SELECT, 8'h31);
    fr(8, 0, 16'h00C3);
    chk(i_host.cap_count, 7);
    chk(i_host.cap_bits, 32'h00000019);
    pop(16'hC300);
    end_sim;
  end
endmodule // pcm_highway_port_config_tb
`default_nettype wire
